/* File: shared/dpm_pkg.sv */
// constants, timing figures and carrier types of the dual-port memory host
package dpm_pkg;

    // clock, counter and bus sizing
    localparam int CLK_PERIOD_NS = 8;
    localparam int CNT_W         = 4;
    localparam int DATA_W        = 18;
    localparam int ADDR_W        = 16;

    typedef logic [CNT_W-1:0] dpmCount_t;

    // least times round up, never below one cycle
    function automatic int dpmCeilCycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // times in ns, slowest grade, so one build serves every grade
    localparam int READ_CYCLE_TIME_NS                = 25;
    localparam int SELECT_TO_WRITE_END_NS            = 20;
    localparam int WRITE_PULSE_NS                    = 22;
    localparam int FLAG_ADDR_ACCESS_NS               = 25;
    localparam int FLAG_UPDATE_GAP_NS                = 12;
    localparam int FLAG_WRITE_TO_READ_GAP_NS         = 5;
    localparam int ARB_LOW_FROM_MATCH_NS             = 20;
    localparam int SLAVE_WRITE_HOLD_AFTER_RELEASE_NS = 17;
    localparam int ARB_RELEASE_TO_DATA_NS            = 25;

    // cycle counts derived from the times above, SEM_ARB_CYC and PLAIN_GAP_CYC fixed at one
    localparam dpmCount_t ARB_CYC = dpmCount_t'(
        dpmCeilCycles(ARB_LOW_FROM_MATCH_NS));
    localparam dpmCount_t SEM_ARB_CYC = 4'h1;
    localparam dpmCount_t WR_ACT_CYC = dpmCount_t'(dpmCeilCycles(
        (WRITE_PULSE_NS > SELECT_TO_WRITE_END_NS) ?
        WRITE_PULSE_NS : SELECT_TO_WRITE_END_NS));
    localparam dpmCount_t RD_ACT_CYC = dpmCount_t'(dpmCeilCycles(
        (READ_CYCLE_TIME_NS > FLAG_ADDR_ACCESS_NS) ?
        READ_CYCLE_TIME_NS : FLAG_ADDR_ACCESS_NS));
    localparam dpmCount_t WR_HOLD_CYC = dpmCount_t'(
        dpmCeilCycles(SLAVE_WRITE_HOLD_AFTER_RELEASE_NS));
    localparam dpmCount_t RD_HOLD_CYC = dpmCount_t'(
        dpmCeilCycles(ARB_RELEASE_TO_DATA_NS));
    localparam dpmCount_t SEM_GAP_CYC = dpmCount_t'(dpmCeilCycles(
        (FLAG_UPDATE_GAP_NS > FLAG_WRITE_TO_READ_GAP_NS) ?
        FLAG_UPDATE_GAP_NS : FLAG_WRITE_TO_READ_GAP_NS));
    localparam dpmCount_t PLAIN_GAP_CYC = 4'h1;
    // strictly more than one read cycle after supply is good
    localparam dpmCount_t PWR_CYC = dpmCount_t'(
        dpmCeilCycles(READ_CYCLE_TIME_NS) + 1);

    typedef enum logic [1:0] {
        OP_MEM_RD = 2'h0,
        OP_MEM_WR = 2'h1,
        OP_SEM_RD = 2'h2,
        OP_SEM_WR = 2'h3
    } dpmOp_t;

    typedef enum logic [2:0] {
        ST_OFF  = 3'h0,
        ST_IDLE = 3'h1,
        ST_ARB  = 3'h3,
        ST_ACT  = 3'h2,
        ST_GAP  = 3'h6
    } dpmState_t;

    typedef struct packed {
        dpmOp_t              op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
        logic                upperEn;
        logic                lowerEn;
    } dpmCmd_t;

    typedef struct packed {
        logic                ceN;
        logic                writeNotRead;
        logic                oeN;
        logic                upperByteStrobeN;
        logic                lowerByteStrobeN;
        logic                flagLatchSelectN;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
        logic                dataOe;
    } dpmPins_t;

    localparam dpmPins_t PINS_IDLE = '{
        ceN: 1'b1, writeNotRead: 1'b1, oeN: 1'b1,
        upperByteStrobeN: 1'b1, lowerByteStrobeN: 1'b1,
        flagLatchSelectN: 1'b1, addr: '0, data: '0, dataOe: 1'b0};

    typedef struct packed {
        dpmCount_t cnt;
    } dpmTimer_t;

    typedef struct packed {
        dpmState_t           st;
        dpmCmd_t             cmd;
        dpmPins_t            pins;
        logic                cmdReady;
        logic                rspValid;
        logic [DATA_W-1:0]   rspData;
        logic                mailPending;
    } dpmHost_t;

endpackage

/* File: logic/dpm_tick_timer.sv */
// down-counter that flags the last cycle of a loaded interval
`timescale 1ns/100ps
`default_nettype none
module dpm_tick_timer
    import dpm_pkg::*;
(
    // clock and reset
    input  wire logic           mclk,
    input  wire logic           srst,
    // load and status
    input  wire logic           load,
    input  wire dpm_pkg::dpmCount_t loadValue,
    output logic                lastCycle
);
    dpmTimer_t timer_reg;
    dpmTimer_t timer_next;

    always_comb begin
        timer_next = timer_reg;
        if (load) begin
            timer_next.cnt = loadValue;
        end else if (timer_reg.cnt != '0) begin
            timer_next.cnt = timer_reg.cnt - 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            timer_reg <= '{cnt: 4'h0};
        end else begin
            timer_reg <= timer_next;
        end
    end

    // an interval loaded with n lasts exactly n cycles
    assign lastCycle = (timer_reg.cnt <= 4'h1);
endmodule
`default_nettype wire

/* File: logic/dpm_host_port.sv */
// host controller driving one port of an asynchronous dual-port memory
//
// Contract
// - host picks memory or flag access, never both, held to write end
// - host idles flag select and output enable for the update gap
// - host waits the write-to-read gap before checking a flag
// - slave-role write stays active the hold time after busy rises
// - host keeps chip select inactive in retention and supply ramps
// - host waits over one read cycle after supply good before access
`timescale 1ns/100ps
`default_nettype none
module dpm_host_port
    import dpm_pkg::*;
(
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    srst,
    // supply status
    input  wire logic                    powerGood,
    input  wire logic                    retainReq,
    // command
    input  wire logic                    cmdValid,
    output logic                         cmdReady,
    input  wire dpm_pkg::dpmCmd_t        cmd,
    // response
    output logic                         rspValid,
    output logic [dpm_pkg::DATA_W-1:0]   rspData,
    // memory port pins
    output dpm_pkg::dpmPins_t            pins,
    input  wire logic [dpm_pkg::DATA_W-1:0] dataIn,
    input  wire logic                    busyN,
    input  wire logic                    mailIntN,
    // mailbox status
    output logic                         mailPending
);
    dpmHost_t  host_reg;
    dpmHost_t  host_next;
    logic      tLoad;
    dpmCount_t tValue;
    logic      tLast;
    logic      curSem;
    logic      curWrite;
    logic      inSem;
    logic      offReq;

    dpm_tick_timer u_timer (
        .mclk      (mclk),
        .srst      (srst),
        .load      (tLoad),
        .loadValue (tValue),
        .lastCycle (tLast)
    );

    assign curSem   = host_reg.cmd.op[1];
    assign curWrite = host_reg.cmd.op[0];
    assign inSem    = cmd.op[1];
    assign offReq   = !powerGood || retainReq;

    always_comb begin
        host_next             = host_reg;
        host_next.rspValid    = 1'b0;
        host_next.cmdReady    = 1'b0;
        host_next.mailPending = !mailIntN;
        tLoad                 = 1'b0;
        tValue                = 4'h0;
        case (host_reg.st)
            ST_OFF: begin
                host_next.pins = PINS_IDLE;
                if (offReq) begin
                    tLoad  = 1'b1;
                    tValue = PWR_CYC;
                end else if (tLast) begin
                    host_next.st       = ST_IDLE;
                    host_next.cmdReady = 1'b1;
                end
            end
            ST_IDLE: begin
                host_next.cmdReady = 1'b1;
                if (cmdValid && host_reg.cmdReady) begin
                    host_next.cmdReady  = 1'b0;
                    host_next.cmd       = cmd;
                    host_next.st        = ST_ARB;
                    host_next.pins.addr = cmd.addr;
                    tLoad               = 1'b1;
                    // exactly one of the two selects goes low
                    if (inSem) begin
                        host_next.pins.flagLatchSelectN = 1'b0;
                        tValue = SEM_ARB_CYC;
                    end else begin
                        host_next.pins.ceN = 1'b0;
                        // let busy settle before any write
                        tValue = ARB_CYC;
                    end
                end
            end
            ST_ARB: begin
                if (tLast) begin
                    host_next.st = ST_ACT;
                    tLoad        = 1'b1;
                    if (!curSem) begin
                        host_next.pins.upperByteStrobeN =
                            !host_reg.cmd.upperEn;
                        host_next.pins.lowerByteStrobeN =
                            !host_reg.cmd.lowerEn;
                    end
                    if (curWrite) begin
                        host_next.pins.writeNotRead = 1'b0;
                        host_next.pins.data         = host_reg.cmd.data;
                        host_next.pins.dataOe       = 1'b1;
                        tValue = WR_ACT_CYC;
                    end else begin
                        host_next.pins.oeN = 1'b0;
                        tValue = RD_ACT_CYC;
                    end
                end
            end
            ST_ACT: begin
                if (!curSem && !busyN) begin
                    // blocked: keep the access and restart the hold
                    tLoad = 1'b1;
                    if (curWrite) begin
                        tValue = WR_HOLD_CYC;
                    end else begin
                        tValue = RD_HOLD_CYC;
                    end
                end else if (tLast) begin
                    if (!curWrite) begin
                        host_next.rspValid = 1'b1;
                        host_next.rspData  = dataIn;
                    end
                    host_next.pins = PINS_IDLE;
                    host_next.st   = ST_GAP;
                    tLoad          = 1'b1;
                    // flag and output enable idle before a check read
                    if (host_reg.cmd.op == OP_SEM_WR) begin
                        tValue = SEM_GAP_CYC;
                    end else begin
                        tValue = PLAIN_GAP_CYC;
                    end
                end
            end
            ST_GAP: begin
                if (tLast) begin
                    host_next.st       = ST_IDLE;
                    host_next.cmdReady = 1'b1;
                end
            end
            default: begin
                host_next.st   = ST_OFF;
                host_next.pins = PINS_IDLE;
            end
        endcase
        // supply loss or retention aborts any access at once
        if (offReq) begin
            host_next.st       = ST_OFF;
            host_next.pins     = PINS_IDLE;
            host_next.cmdReady = 1'b0;
            host_next.rspValid = 1'b0;
            tLoad              = 1'b1;
            tValue             = PWR_CYC;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            host_reg <= '{st: ST_OFF, cmd: '0, pins: PINS_IDLE,
                          cmdReady: 1'b0, rspValid: 1'b0, rspData: '0,
                          mailPending: 1'b0};
        end else begin
            host_reg <= host_next;
        end
    end

    assign cmdReady    = host_reg.cmdReady;
    assign rspValid    = host_reg.rspValid;
    assign rspData     = host_reg.rspData;
    assign pins        = host_reg.pins;
    assign mailPending = host_reg.mailPending;

    a_sel_exclusive: assert property (
        @(posedge mclk) disable iff (srst)
        !(!pins.ceN && !pins.flagLatchSelectN))
        else $error("memory and flag selected together");

    a_sel_hold: assert property (
        @(posedge mclk) disable iff (srst)
        (!pins.writeNotRead && $past(!pins.writeNotRead)) |->
        ($stable(pins.ceN) && $stable(pins.flagLatchSelectN)
         && $stable(pins.addr)))
        else $error("select changed inside a write");

    a_write_len: assert property (
        @(posedge mclk) disable iff (srst || offReq)
        $fell(pins.writeNotRead) |-> (!pins.writeNotRead)[*3])
        else $error("write shorter than select to write end");

    a_sem_gap: assert property (
        @(posedge mclk) disable iff (srst)
        ($past(!pins.flagLatchSelectN && !pins.writeNotRead)
         && pins.writeNotRead) |->
        (pins.flagLatchSelectN && pins.oeN)[*2])
        else $error("flag update gap too short");

    a_off_deselect: assert property (
        @(posedge mclk) disable iff (srst)
        offReq |=> (pins.ceN && pins.flagLatchSelectN && !cmdReady))
        else $error("port selected during retention");

    a_power_wait: assert property (
        @(posedge mclk) disable iff (srst)
        $rose(powerGood) |=> (pins.ceN && pins.flagLatchSelectN)[*4])
        else $error("access too soon after supply good");

    a_arb_settle: assert property (
        @(posedge mclk) disable iff (srst || offReq)
        $fell(pins.ceN) |-> (pins.writeNotRead && pins.oeN)[*3])
        else $error("access before busy settled");

    a_busy_hold: assert property (
        @(posedge mclk) disable iff (srst || offReq)
        ($rose(busyN) && !pins.writeNotRead && !pins.ceN) |->
        (!pins.writeNotRead)[*3])
        else $error("write released too soon after busy");

    a_busy_read: assert property (
        @(posedge mclk) disable iff (srst || offReq)
        ($rose(busyN) && !pins.oeN && !pins.ceN) |->
        (!rspValid && !pins.oeN)[*4])
        else $error("read sampled before data valid");
endmodule
`default_nettype wire

/* File: bench/dpm_dev_model.sv */
// behavioural model of the dual-port memory seen from its left port
`timescale 1ns/100ps
`default_nettype none
module dpm_dev_model (
    // clock
    input  wire logic                       mclk,
    // left port pins and resolved data lanes
    input  wire dpm_pkg::dpmPins_t          pins,
    input  wire logic [dpm_pkg::DATA_W-1:0] wireData,
    // lane drive, busy and mailbox flags
    output logic [dpm_pkg::DATA_W-1:0]      devData,
    output logic [dpm_pkg::DATA_W-1:0]      devEn,
    output logic                            busyN,
    output logic                            mailIntN,
    output logic                            rightIntN
);
    import dpm_pkg::*;
    logic [DATA_W-1:0] mem [0:65535];
    logic [DATA_W-1:0] wd;
    logic [ADDR_W-1:0] otherAddr, wa;
    logic [2:0]        swIdx;
    logic              memWr, memRd, flagSel, semWr, semRd, semBit;
    logic              otherOn, wasWr, wu, wl, semWrPrev, semRdPrev;
    logic              swBit, semLatch;
    dpmPins_t          p;
    int                own [0:7];
    bit                pend [1:2][0:7];
    int                wCnt, gapCnt;

    initial begin
        foreach (mem[i]) mem[i] = '0;
        foreach (own[i]) own[i] = 0;
        {otherOn, wasWr, semWrPrev, semRdPrev} = '0;
        {busyN, mailIntN, rightIntN} = '1;
        wCnt = 0;
        gapCnt = 9;
    end

    // port 1 is the host side, port 2 the far side
    task automatic semUpdate(input int q, input int i, input bit v);
        if (!v && own[i] == 0)
            own[i] = q;
        else if (!v && own[i] != q)
            pend[q][i] = 1'b1;
        else if (v && own[i] == q) begin
            own[i] = pend[3-q][i] ? 3 - q : 0;
            pend[3-q][i] = 1'b0;
        end else if (v)
            pend[q][i] = 1'b0;
    endtask
    task automatic otherSem(input int i, input bit v);
        semUpdate(2, i, v);
    endtask
    task automatic otherHold(input logic [ADDR_W-1:0] ad);
        otherAddr = ad;
        otherOn = 1'b1;
    endtask
    task automatic otherRelease();
        otherOn = 1'b0;
    endtask
    task automatic otherMail();
        mailIntN = 1'b0;
    endtask

    assign p = pins;
    assign memWr = !p.ceN && !p.writeNotRead && p.flagLatchSelectN
        && !(p.upperByteStrobeN && p.lowerByteStrobeN);
    assign memRd = !p.ceN && p.writeNotRead && !p.oeN
        && p.flagLatchSelectN;
    assign flagSel = !p.flagLatchSelectN
        && (p.ceN || (p.upperByteStrobeN && p.lowerByteStrobeN));
    assign semWr = flagSel && !p.writeNotRead;
    assign semRd = flagSel && p.writeNotRead && !p.oeN;

    always @* begin
        semBit = (own[p.addr[2:0]] == 1) ? 1'b0 : 1'b1;
        devEn = '0;
        devData = '0;
        if (memRd) begin
            devEn = {{9{!p.upperByteStrobeN}}, {9{!p.lowerByteStrobeN}}};
            // data is not valid while the port is held off
            devData = busyN ? mem[p.addr] : ~mem[p.addr];
        end else if (semRd) begin
            devEn = '1;
            // reading back too soon after a flag write gives garbage
            devData = {DATA_W{(semRdPrev ? semLatch : semBit)
                ^ (gapCnt < 2)}};
        end
    end

    always @(posedge mclk) begin
        busyN <= !(otherOn && !p.ceN && p.addr == otherAddr);
        wasWr <= memWr;
        semWrPrev <= semWr;
        semRdPrev <= semRd;
        if (semRd && !semRdPrev)
            semLatch <= semBit;
        if (memWr) begin
            wa <= p.addr;
            wd <= wireData;
            wu <= !p.upperByteStrobeN;
            wl <= !p.lowerByteStrobeN;
            wCnt <= busyN ? wCnt + 1 : 0;
        end else begin
            // a write dropped too soon after busy rises is lost
            if (wasWr && wCnt >= 3) begin
                if (wu)
                    mem[wa][17:9] <= wd[17:9];
                if (wl)
                    mem[wa][8:0] <= wd[8:0];
                if (wa == 16'h7FFF)
                    rightIntN <= 1'b0;
            end
            wCnt <= 0;
        end
        if (memRd && busyN && p.addr == 16'h7FFE)
            mailIntN <= 1'b1;
        if (semWr) begin
            swIdx <= p.addr[2:0];
            swBit <= wireData[0];
            gapCnt <= 0;
        end else if (gapCnt < 9)
            gapCnt <= gapCnt + 1;
        if (semWrPrev && !semWr)
            semUpdate(1, swIdx, swBit);
    end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// self-checking testbench of the dual-port memory host port
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dpm_pkg::*;
    logic mclk, srst, powerGood, retainReq, cmdValid, cmdReady, rspValid;
    logic mailPending, busyN, mailIntN, rightIntN, ue, le;
    logic [DATA_W-1:0] rspData, wireData, lastWire, devData, devEn, d;
    logic [DATA_W-1:0] expMem [0:65535];
    logic [ADDR_W-1:0] a;
    dpmCmd_t  cmd;
    dpmPins_t pins;
    int fails, checked, seed, n;
    // step: acting port (1 host, 2 far), value written, host read
    int semTab [0:9][0:2] = '{'{1,0,0}, '{2,0,0}, '{1,1,1}, '{1,0,1},
        '{2,1,0}, '{1,1,1}, '{2,0,1}, '{2,1,1}, '{1,0,0}, '{1,1,1}};

    dpm_host_port i_dut (.mclk(mclk), .srst(srst), .powerGood(powerGood),
        .retainReq(retainReq), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmd(cmd), .rspValid(rspValid), .rspData(rspData), .pins(pins),
        .dataIn(wireData), .busyN(busyN), .mailIntN(mailIntN),
        .mailPending(mailPending));
    dpm_dev_model i_dev (.mclk(mclk), .pins(pins), .wireData(wireData),
        .devData(devData), .devEn(devEn), .busyN(busyN),
        .mailIntN(mailIntN), .rightIntN(rightIntN));

    // released lanes show the inverse of their last level
    assign wireData = (devEn & devData)
        | (~devEn & (pins.dataOe ? pins.data : ~lastWire));
    always #4 mclk = ~mclk;
    always @(posedge mclk) lastWire <= wireData;

    task automatic stop_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cmpWord(input string nm, input logic [DATA_W-1:0] e, g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmpBit(input string nm, input logic e, g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic doCmd(input dpmOp_t op, input logic [ADDR_W-1:0] ad,
        input logic [DATA_W-1:0] dt, input logic u, l);
        int k;
        k = 0;
        while (cmdReady !== 1'b1 && k < 200) begin
            @(negedge mclk);
            k++;
        end
        cmd = '{op: op, addr: ad, data: dt, upperEn: u, lowerEn: l};
        cmdValid = 1'b1;
        @(negedge mclk);
        cmdValid = 1'b0;
        while (op inside {OP_MEM_RD, OP_SEM_RD} && rspValid !== 1'b1
            && k < 200) begin
            @(negedge mclk);
            k++;
        end
        if (k >= 200) begin
            cmpBit("handshake", 1'b1, 1'b0);
            stop_test();
        end
    endtask
    task automatic memWrite(input logic [ADDR_W-1:0] ad,
        input logic [DATA_W-1:0] dt, input logic u, l);
        doCmd(OP_MEM_WR, ad, dt, u, l);
        if (u)
            expMem[ad][17:9] = dt[17:9];
        if (l)
            expMem[ad][8:0] = dt[8:0];
    endtask
    task automatic memCheck(input string nm, input logic [ADDR_W-1:0] ad,
        input logic u, l);
        logic [DATA_W-1:0] mk;
        mk = {{9{u}}, {9{l}}};
        doCmd(OP_MEM_RD, ad, '0, u, l);
        cmpWord(nm, expMem[ad] & mk, rspData & mk);
    endtask

    always @(negedge mclk)
        if (srst === 1'b0) begin
            cmpBit("dual select", 1'b0, !pins.ceN && !pins.flagLatchSelectN);
            cmpBit("drive in read", 1'b0, pins.dataOe && !pins.oeN);
        end

    initial begin
        #800000;
        cmpBit("run length", 1'b1, 1'b0);
        stop_test();
    end

    initial begin
        mclk = 0;
        srst = 1;
        powerGood = 0;
        retainReq = 0;
        cmdValid = 0;
        cmd = '0;
        lastWire = '0;
        fails = 0;
        checked = 0;
        seed = 22051;
        foreach (expMem[i]) expMem[i] = '0;
        repeat (3) @(negedge mclk);
        srst = 1'b0;
        @(negedge mclk);
        cmpBit("idle pins", 1'b1, pins === PINS_IDLE);
        powerGood = 1'b1;
        n = 0;
        while (cmdReady !== 1'b1 && n < 50) begin
            cmpBit("select at power up", 1'b1, pins.ceN);
            @(negedge mclk);
            n++;
        end
        cmpBit("power up wait", 1'b1, n > 3);
        $display("test power up done");
        repeat (12) begin
            a = ADDR_W'($random(seed)) & 16'h7FEF;
            {ue, le} = 2'($random(seed));
            le = le | !ue;
            memWrite(a, DATA_W'($random(seed)), ue, le);
            {ue, le} = 2'($random(seed));
            le = le | !ue;
            memCheck("memory word", a, ue, le);
        end
        $display("test memory done");
        for (int i = 0; i < 8; i++)
            for (int s = 0; s < 10; s++) begin
                a = ADDR_W'($random(seed));
                a[2:0] = 3'(i);
                d = DATA_W'($random(seed));
                d[0] = semTab[s][1][0];
                if (semTab[s][0] == 1)
                    doCmd(OP_SEM_WR, a, d, ue, le);
                else
                    i_dev.otherSem(i, d[0]);
                doCmd(OP_SEM_RD, a, '0, ue, le);
                cmpWord("flag", {DATA_W{semTab[s][2][0]}}, rspData);
            end
        $display("test flags done");
        memWrite(16'h7FFF, DATA_W'($random(seed)), 1'b1, 1'b1);
        repeat (10) @(negedge mclk);
        cmpBit("right mailbox", 1'b0, rightIntN);
        i_dev.otherMail();
        repeat (3) @(negedge mclk);
        cmpBit("mail pending", 1'b1, mailPending);
        i_dev.otherHold(16'h7FFE);
        fork
            doCmd(OP_MEM_RD, 16'h7FFE, '0, 1'b1, 1'b1);
            begin
                repeat (10) @(negedge mclk);
                cmpBit("mail under busy", 1'b1, mailPending);
                i_dev.otherRelease();
            end
        join
        cmpWord("mailbox word", expMem[16'h7FFE], rspData);
        repeat (3) @(negedge mclk);
        cmpBit("mail cleared", 1'b0, mailPending);
        $display("test mailbox done");
        a = 16'h1234;
        i_dev.otherHold(a);
        fork
            memWrite(a, DATA_W'($random(seed)), 1'b1, 1'b1);
            begin
                repeat (12) @(negedge mclk);
                i_dev.otherRelease();
            end
        join
        memCheck("word after busy", a, 1'b1, 1'b1);
        $display("test busy done");
        doCmd(OP_MEM_WR, 16'h7FF0, '0, 1'b1, 1'b1);
        retainReq = 1'b1;
        @(negedge mclk);
        repeat (9) begin
            @(negedge mclk);
            cmpBit("select in retention", 1'b1, pins.ceN);
        end
        retainReq = 1'b0;
        memCheck("after retention", a, 1'b1, 1'b1);
        $display("test retention done");
        stop_test();
    end
endmodule
`default_nettype wire
